// [design/irq_defs.vh]
// Register indices, field positions, reset values and codes of the pin interrupt block.
//
// What this block does
// R01: Sensed edge or change on line 0 sets flag.
// R02: Line-0 flag with both enables requests vector.
// R03: Core vector acknowledge clears matching flag.
// R04: Writing one to a flag clears it.
// R05: Low-level sensing keeps line-0 flag cleared.
// R06: Group-1 enable gates lines 8 to 11.
// R07: Group-0 enable gates lines 0 to 7.
// R08: Change on lines 8 to 11 sets group-1 flag.
// R09: Change on lines 0 to 7 sets group-0 flag.
// R10: Group-1 flag with both enables requests vector.
// R11: Group-0 flag with both enables requests vector.
// R12: Low mask bits gate lines 0 to 7.
// R13: High mask bits 0-3 gate lines 8-11.
// R14: Sense codes: low, any, falling, rising.
// R15: Pin changes detected without any I/O clock.
// R16: Line-0 enable needs its mask and global enable.
// R17: Zero writes and unused bits have no effect.
// R18: Set beats clear in the same cycle.
`ifndef IRQ_DEFS_VH
`define IRQ_DEFS_VH

// Register indices; the byte address is four times the index.
`define IDX_PINCHG_MASK_LOW 6'h0F
`define IDX_PINCHG_MASK_HIGH 6'h10
`define IDX_PINCHG_FLAGS 6'h11
`define IDX_PINCHG_CONTROL 6'h12
`define IDX_EXT_MASK 6'h13
`define IDX_EXT_FLAGS 6'h14
`define IDX_EXT_SENSE 6'h15
`define IDX_GLOBAL_ENABLE 6'h16
`define IDX_IRQ_STATUS 6'h17
`define IDX_IRQ_ENABLE 6'h18
`define IDX_IRQ_CLEAR 6'h19

// Field positions.
`define BIT_GROUP0 0
`define BIT_GROUP1 1
`define BIT_LINE0 0
`define BIT_EVT_LINE0 0
`define BIT_EVT_GROUP0 1
`define BIT_EVT_GROUP1 2

// Reset value shared by every register.
`define REG_RESET 8'h00

// Sense codes for line 0.
`define SENSE_LOW 2'h0
`define SENSE_ANY 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [design/pin_sync.v]
// Two-stage synchroniser for a group of asynchronous interrupt pins.
`timescale 1ns/1ps

module pin_sync #(
  parameter WIDTH = 13
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] pins,
  output wire [WIDTH-1:0] pins_sync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // Each pin gets its own pair of flops; only the second stage is read outside.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= pins[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign pins_sync = sync_q;

endmodule

// [design/pin_irq_ctrl.v]
// External line 0 and pin-change interrupt flags with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "irq_defs.vh"

module pin_irq_ctrl #(
  parameter ADDR_WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address channel.
  input wire [ADDR_WIDTH-1:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  // AXI4-Lite write data channel.
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // AXI4-Lite write response channel.
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read address channel.
  input wire [ADDR_WIDTH-1:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  // AXI4-Lite read data channel.
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Interrupt pins, asynchronous to aclk.
  input wire ext_line0,
  input wire [7:0] pinchg_lines_low,
  input wire [3:0] pinchg_lines_high,
  // Vector acknowledges from the core, one-cycle pulses on aclk.
  input wire ext_line0_ack,
  input wire pinchg_group0_ack,
  input wire pinchg_group1_ack,
  // Vector requests toward the core.
  output reg ext_line0_vector,
  output reg pinchg_group0_vector,
  output reg pinchg_group1_vector,
  // Summary interrupt for the bus-side status register.
  output reg irq
);

  // Maps a byte address onto a word index; addresses beyond the index width are unmapped.
  function [6:0] reg_index;
    input [ADDR_WIDTH-1:0] addr;
    reg [ADDR_WIDTH-1:0] word;
    begin
      word = addr >> 2;
      if (word > {{(ADDR_WIDTH-6){1'b0}}, 6'h3F}) begin
        reg_index = 7'h7F;
      end else begin
        reg_index = {1'b0, word[5:0]};
      end
    end
  endfunction

  // True when a word index names a register of this block.
  function is_mapped;
    input [6:0] idx;
    begin
      is_mapped = (idx >= {1'b0, `IDX_PINCHG_MASK_LOW}) &&
                  (idx <= {1'b0, `IDX_IRQ_CLEAR});
    end
  endfunction

  // Software-visible registers.
  reg [7:0] pinchg_mask_low;
  reg [3:0] pinchg_mask_high;
  reg [1:0] pinchg_control_reg;
  reg ext_irq_mask_reg;
  reg [1:0] ext_line0_sense;
  reg global_enable_q;
  reg [2:0] irq_enable_q;

  // Hardware-set flags.
  reg pinchg_group0_flag;
  reg pinchg_group1_flag;
  reg ext_line0_flag;
  reg [2:0] irq_status_q;

  // Pin history for edge and change detection.
  reg [12:0] pins_prev_q;
  reg primed_q;
  wire [12:0] pins_now;

  // Write channel holding state.
  reg aw_have_q;
  reg w_have_q;
  reg [ADDR_WIDTH-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  // Combinational decode of the write that completes this cycle.
  reg wr_fire;
  reg [6:0] wr_idx;
  reg wr_lane0;
  reg [7:0] wr_byte;

  // Event terms.
  reg ext_evt;
  reg group0_evt;
  reg group1_evt;
  reg [11:0] line_change;
  reg [2:0] evt_vec;
  reg [2:0] status_clr;

  // Next-state terms.
  reg pinchg_group0_flag_d;
  reg pinchg_group1_flag_d;
  reg ext_line0_flag_d;
  reg ext_req_d;
  reg [7:0] rd_byte;

  // The pins are sampled on aclk only, so no gated I/O clock is needed to see a change.
  pin_sync #(
    .WIDTH(13)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins({pinchg_lines_high, pinchg_lines_low, ext_line0}), // R15
    .pins_sync(pins_now)
  );

  // Keep the previous synchronised sample; primed_q masks events only in the first cycle after reset, before the synchroniser output can change.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pins_prev_q <= 13'h0000;
      primed_q <= 1'b0;
    end else begin
      pins_prev_q <= pins_now;
      primed_q <= 1'b1;
    end
  end

  // Event detection on line 0 and on the two masked pin-change groups.
  always @* begin
    line_change = pins_now[12:1] ^ pins_prev_q[12:1];
    case (ext_line0_sense) // R14
      `SENSE_ANY: ext_evt = pins_now[0] ^ pins_prev_q[0]; // R01
      `SENSE_FALL: ext_evt = ~pins_now[0] & pins_prev_q[0]; // R01
      `SENSE_RISE: ext_evt = pins_now[0] & ~pins_prev_q[0]; // R01
      default: ext_evt = 1'b0;
    endcase
    ext_evt = ext_evt & primed_q;
    group0_evt = primed_q & |(line_change[7:0] & pinchg_mask_low); // R12
    group1_evt = primed_q & |(line_change[11:8] & pinchg_mask_high); // R13
    evt_vec = 3'h0;
    evt_vec[`BIT_EVT_LINE0] = ext_evt;
    evt_vec[`BIT_EVT_GROUP0] = group0_evt;
    evt_vec[`BIT_EVT_GROUP1] = group1_evt;
  end

  // A write lands once, at the edge that raises bvalid, so a W1C write never clears twice.
  always @* begin
    wr_fire = aw_have_q & w_have_q & ~bvalid;
    wr_idx = reg_index(aw_addr_q);
    wr_lane0 = w_strb_q[0];
    wr_byte = w_data_q[7:0];
  end

  // Flag next values: a hardware set in the same cycle overrides any clear.
  always @* begin
    pinchg_group0_flag_d = pinchg_group0_flag;
    pinchg_group1_flag_d = pinchg_group1_flag;
    ext_line0_flag_d = ext_line0_flag;
    status_clr = 3'h0;
    if (pinchg_group0_ack) begin
      pinchg_group0_flag_d = 1'b0; // R03
    end
    if (pinchg_group1_ack) begin
      pinchg_group1_flag_d = 1'b0; // R03
    end
    if (ext_line0_ack) begin
      ext_line0_flag_d = 1'b0; // R03
    end
    // Writing zero leaves a flag alone; only ones clear.
    if (wr_fire && wr_lane0) begin
      if (wr_idx == {1'b0, `IDX_PINCHG_FLAGS}) begin
        if (wr_byte[`BIT_GROUP0]) begin
          pinchg_group0_flag_d = 1'b0; // R04 R17
        end
        if (wr_byte[`BIT_GROUP1]) begin
          pinchg_group1_flag_d = 1'b0; // R04 R17
        end
      end
      if (wr_idx == {1'b0, `IDX_EXT_FLAGS} && wr_byte[`BIT_LINE0]) begin
        ext_line0_flag_d = 1'b0; // R04 R17
      end
      if (wr_idx == {1'b0, `IDX_IRQ_CLEAR}) begin
        status_clr = wr_byte[2:0];
      end
    end
    if (group0_evt) begin
      pinchg_group0_flag_d = 1'b1; // R09 R18
    end
    if (group1_evt) begin
      pinchg_group1_flag_d = 1'b1; // R08 R18
    end
    if (ext_evt) begin
      ext_line0_flag_d = 1'b1; // R01 R18
    end
    // Level sensing never leaves a flag behind; the pin itself carries the request.
    if (ext_line0_sense == `SENSE_LOW) begin
      ext_line0_flag_d = 1'b0; // R05
    end
  end

  // In level mode the request follows the pin low level instead of the flag.
  always @* begin
    if (ext_line0_sense == `SENSE_LOW) begin
      ext_req_d = ~pins_now[0] & primed_q;
    end else begin
      ext_req_d = ext_line0_flag;
    end
    ext_req_d = ext_req_d & ext_irq_mask_reg & global_enable_q; // R02 R16
  end

  // Flags, status and the vector requests; all requests come from flops.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pinchg_group0_flag <= 1'b0;
      pinchg_group1_flag <= 1'b0;
      ext_line0_flag <= 1'b0;
      irq_status_q <= 3'h0;
      ext_line0_vector <= 1'b0;
      pinchg_group0_vector <= 1'b0;
      pinchg_group1_vector <= 1'b0;
      irq <= 1'b0;
    end else begin
      pinchg_group0_flag <= pinchg_group0_flag_d;
      pinchg_group1_flag <= pinchg_group1_flag_d;
      ext_line0_flag <= ext_line0_flag_d;
      irq_status_q <= (irq_status_q & ~status_clr) | evt_vec; // R18
      ext_line0_vector <= ext_req_d; // R02
      pinchg_group0_vector <= pinchg_group0_flag &
                              pinchg_control_reg[`BIT_GROUP0] & global_enable_q; // R07 R11
      pinchg_group1_vector <= pinchg_group1_flag &
                              pinchg_control_reg[`BIT_GROUP1] & global_enable_q; // R06 R10
      irq <= |(irq_status_q & irq_enable_q);
    end
  end

  // Control registers; bits beyond each field are dropped on write.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pinchg_mask_low <= `REG_RESET;
      pinchg_mask_high <= 4'h0;
      pinchg_control_reg <= 2'h0;
      ext_irq_mask_reg <= 1'b0;
      ext_line0_sense <= `SENSE_LOW;
      global_enable_q <= 1'b0;
      irq_enable_q <= 3'h0;
    end else if (wr_fire && wr_lane0) begin
      case (wr_idx)
        {1'b0, `IDX_PINCHG_MASK_LOW}: pinchg_mask_low <= wr_byte; // R12
        {1'b0, `IDX_PINCHG_MASK_HIGH}: pinchg_mask_high <= wr_byte[3:0]; // R13 R17
        {1'b0, `IDX_PINCHG_CONTROL}: pinchg_control_reg <= wr_byte[1:0]; // R17
        {1'b0, `IDX_EXT_MASK}: ext_irq_mask_reg <= wr_byte[`BIT_LINE0]; // R16
        {1'b0, `IDX_EXT_SENSE}: ext_line0_sense <= wr_byte[1:0]; // R14
        {1'b0, `IDX_GLOBAL_ENABLE}: global_enable_q <= wr_byte[0];
        {1'b0, `IDX_IRQ_ENABLE}: irq_enable_q <= wr_byte[2:0];
        default: ;
      endcase
    end
  end

  // Write channel: address and data may arrive in either order and are held until used.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= {ADDR_WIDTH{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      // Ready is offered one cycle ahead so a handshake lands on a registered ready.
      awready <= ~aw_have_q & ~(awvalid & awready) & ~bvalid;
      wready <= ~w_have_q & ~(wvalid & wready) & ~bvalid;
      if (aw_have_q && w_have_q && !bvalid) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
        awready <= 1'b0;
        wready <= 1'b0;
      end
    end
  end

  // Read mux; unused bits and the write-only clear register read as zero.
  always @* begin
    case (reg_index(araddr))
      {1'b0, `IDX_PINCHG_MASK_LOW}: rd_byte = pinchg_mask_low;
      {1'b0, `IDX_PINCHG_MASK_HIGH}: rd_byte = {4'h0, pinchg_mask_high}; // R17
      {1'b0, `IDX_PINCHG_FLAGS}: rd_byte = {6'h00, pinchg_group1_flag, pinchg_group0_flag};
      {1'b0, `IDX_PINCHG_CONTROL}: rd_byte = {6'h00, pinchg_control_reg};
      {1'b0, `IDX_EXT_MASK}: rd_byte = {7'h00, ext_irq_mask_reg};
      {1'b0, `IDX_EXT_FLAGS}: rd_byte = {7'h00, ext_line0_flag};
      {1'b0, `IDX_EXT_SENSE}: rd_byte = {6'h00, ext_line0_sense};
      {1'b0, `IDX_GLOBAL_ENABLE}: rd_byte = {7'h00, global_enable_q};
      {1'b0, `IDX_IRQ_STATUS}: rd_byte = {5'h00, irq_status_q};
      {1'b0, `IDX_IRQ_ENABLE}: rd_byte = {5'h00, irq_enable_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read channel: one read at a time, data registered at the address handshake.
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_byte};
        rresp <= is_mapped(reg_index(araddr)) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else begin
        arready <= ~rvalid;
      end
    end
  end

endmodule

// [test/irq_checker_properties.sv]
// Port-level assertions for the pin interrupt block.
`timescale 1ns/1ps
`include "irq_defs.vh"
module irq_checker #(
  parameter ADDR_WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire [ADDR_WIDTH-1:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  input wire [7:0] pinchg_lines_low,
  input wire [3:0] pinchg_lines_high,
  input wire pinchg_group0_ack,
  input wire pinchg_group1_ack,
  input wire pinchg_group0_vector,
  input wire pinchg_group1_vector,
  input wire irq
);
  reg [11:0] pins_q;
  reg [3:0] quiet_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counts edges since the last pin change, so an ack is judged only when no set is in flight.
  always @(posedge aclk) begin
    pins_q <= {pinchg_lines_high, pinchg_lines_low};
    if (!aresetn || {pinchg_lines_high, pinchg_lines_low} != pins_q) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  end
  a_bresp_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp lost");
  a_write_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("no write response");
  a_aw_refused:
    assert property (bvalid |-> !awready && !wready) else $error("write taken early");
  a_read_answer:
    assert property (arvalid && arready |=> rvalid) else $error("no read response");
  a_rdata_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata lost");
  a_unmapped_read:
    assert property (arvalid && arready && (araddr[7:2] < `IDX_PINCHG_MASK_LOW ||
      araddr[7:2] > `IDX_IRQ_CLEAR) |=> rresp == `RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read answered");
  a_upper_zero:
    assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("unused bits set");
  a_ack_group0:
    assert property (pinchg_group0_ack && quiet_q > 4'h6 |-> ##2 !pinchg_group0_vector)
      else $error("group0 ack ignored");
  a_ack_group1:
    assert property (pinchg_group1_ack && quiet_q > 4'h6 |-> ##2 !pinchg_group1_vector)
      else $error("group1 ack ignored");
  c_write: cover property (bvalid && bready);
  c_vec0: cover property ($rose(pinchg_group0_vector));
  c_irq: cover property ($rose(irq));
endmodule

bind pin_irq_ctrl irq_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pinchg_lines_low,
  .pinchg_lines_high, .pinchg_group0_ack, .pinchg_group1_ack, .pinchg_group0_vector,
  .pinchg_group1_vector, .irq
);

// [test/irq_far_side.sv]
// Far-side model: the interrupt pins and the core that takes vectors.
`timescale 1ns/1ps
module irq_far_side (
  input wire aclk,
  input wire [2:0] vec,
  output reg [2:0] ack,
  output wire [12:0] pins_out
);
  reg [12:0] pins = 13'h0001;
  reg ack_en = 1'h0;
  integer ack_wait = 8;
  integer cnt [0:2];
  integer i;
  assign pins_out = pins;
  initial begin
    ack = 3'h0;
    for (i = 0; i < 3; i = i + 1) cnt[i] = 0;
  end
  // The core takes a request once after ack_wait edges; later edges find the count past it.
  always @(posedge aclk) begin
    for (i = 0; i < 3; i = i + 1) begin
      ack[i] <= 1'h0;
      if (!ack_en || !vec[i]) cnt[i] <= 0;
      else begin
        cnt[i] <= cnt[i] + 1;
        if (cnt[i] == ack_wait) ack[i] <= 1'h1;
      end
    end
  end
endmodule

// [test/tb_external_and_pin_change_irq.sv]
// Self-checking bench for the pin interrupt block.
`timescale 1ns/1ps
`include "irq_defs.vh"
module tb_external_and_pin_change_irq;
  reg aclk = 1'h0;
  reg aresetn = 1'h0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'h0;
  reg wvalid = 1'h0;
  reg bready = 1'h0;
  reg arvalid = 1'h0;
  reg rready = 1'h0;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] vec, ack;
  wire [12:0] pins;
  integer n_errors = 0;
  integer check_count = 0;
  // Free-running 100 MHz clock.
  always #5 aclk = ~aclk;
  pin_irq_ctrl #(.ADDR_WIDTH(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ext_line0(pins[0]), .pinchg_lines_low(pins[8:1]),
    .pinchg_lines_high(pins[12:9]), .ext_line0_ack(ack[0]), .pinchg_group0_ack(ack[1]),
    .pinchg_group1_ack(ack[2]), .ext_line0_vector(vec[0]), .pinchg_group0_vector(vec[1]),
    .pinchg_group1_vector(vec[2]), .irq(irq)
  );
  irq_far_side u_far (.aclk(aclk), .vec(vec), .ack(ack), .pins_out(pins));
  task automatic chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write; both halves are offered together and each is dropped once taken.
  task automatic wr(input [5:0] idx, input [7:0] d, input [1:0] er);
    integer t;
    t = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      t = t + 1;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && t < 50);
    bready <= 1'h0;
    chk(bresp, er);
  endtask
  // Bus read compared against the expected byte and response.
  task automatic rdr(input [5:0] idx, input [7:0] e, input [1:0] er);
    integer t;
    t = 0;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      t = t + 1;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && t < 50);
    rready <= 1'h0;
    chk(rresp, er);
    chk(rdata, {24'h0, e});
  endtask
  // Pins change at an edge; six edges cover the three-edge flag and four-edge vector delay.
  task automatic pn(input [12:0] v);
    @(posedge aclk);
    u_far.pins <= v;
    repeat (6) @(posedge aclk);
  endtask
  task automatic t_reset;
    integer i;
    for (i = 15; i <= 25; i = i + 1) rdr(i[5:0], 8'h00, `RESP_OKAY);
    rdr(6'h0E, 8'h00, `RESP_SLVERR);
    wr(6'h1A, 8'hFF, `RESP_SLVERR);
  endtask
  task automatic t_group0;
    wr(`IDX_GLOBAL_ENABLE, 8'h01, `RESP_OKAY);
    wr(`IDX_PINCHG_CONTROL, 8'h03, `RESP_OKAY);
    wr(`IDX_PINCHG_MASK_LOW, 8'h04, `RESP_OKAY);
    pn(13'h0005);
    rdr(`IDX_PINCHG_FLAGS, 8'h00, `RESP_OKAY);
    pn(13'h000D);
    rdr(`IDX_PINCHG_FLAGS, 8'h01, `RESP_OKAY);
    chk(vec, 3'h2);
    wr(`IDX_PINCHG_FLAGS, 8'h00, `RESP_OKAY);
    rdr(`IDX_PINCHG_FLAGS, 8'h01, `RESP_OKAY);
    wr(`IDX_PINCHG_FLAGS, 8'h01, `RESP_OKAY);
    rdr(`IDX_PINCHG_FLAGS, 8'h00, `RESP_OKAY);
  endtask
  task automatic t_group1;
    wr(`IDX_PINCHG_MASK_HIGH, 8'hFF, `RESP_OKAY);
    rdr(`IDX_PINCHG_MASK_HIGH, 8'h0F, `RESP_OKAY);
    wr(`IDX_PINCHG_MASK_HIGH, 8'h08, `RESP_OKAY);
    pn(13'h020D);
    rdr(`IDX_PINCHG_FLAGS, 8'h00, `RESP_OKAY);
    pn(13'h1205);
    rdr(`IDX_PINCHG_FLAGS, 8'h03, `RESP_OKAY);
    chk(vec, 3'h6);
    wr(`IDX_PINCHG_CONTROL, 8'h01, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(vec, 3'h2);
    wr(`IDX_PINCHG_CONTROL, 8'h02, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(vec, 3'h4);
    wr(`IDX_PINCHG_CONTROL, 8'h03, `RESP_OKAY);
    u_far.ack_en <= 1'h1;
    repeat (16) @(posedge aclk);
    rdr(`IDX_PINCHG_FLAGS, 8'h00, `RESP_OKAY);
    u_far.ack_en <= 1'h0;
  endtask
  task automatic t_line0;
    integer s;
    wr(`IDX_EXT_MASK, 8'h01, `RESP_OKAY);
    for (s = 1; s < 4; s = s + 1) begin
      wr(`IDX_EXT_SENSE, s[7:0], `RESP_OKAY);
      pn(13'h1204);
      rdr(`IDX_EXT_FLAGS, {7'h0, s != 3}, `RESP_OKAY);
      wr(`IDX_EXT_FLAGS, 8'h01, `RESP_OKAY);
      pn(13'h1205);
      rdr(`IDX_EXT_FLAGS, {7'h0, s != 2}, `RESP_OKAY);
      wr(`IDX_EXT_FLAGS, 8'h01, `RESP_OKAY);
    end
    wr(`IDX_EXT_SENSE, 8'h00, `RESP_OKAY);
    pn(13'h1204);
    rdr(`IDX_EXT_FLAGS, 8'h00, `RESP_OKAY);
    chk(vec, 3'h1);
    wr(`IDX_GLOBAL_ENABLE, 8'h00, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(vec, 3'h0);
    wr(`IDX_GLOBAL_ENABLE, 8'h01, `RESP_OKAY);
    pn(13'h1205);
  endtask
  task automatic t_irq;
    wr(`IDX_IRQ_CLEAR, 8'h07, `RESP_OKAY);
    rdr(`IDX_IRQ_STATUS, 8'h00, `RESP_OKAY);
    wr(`IDX_IRQ_ENABLE, 8'h02, `RESP_OKAY);
    pn(13'h120D);
    rdr(`IDX_IRQ_STATUS, 8'h02, `RESP_OKAY);
    chk(irq, 1'h1);
    wr(`IDX_IRQ_ENABLE, 8'h00, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h0);
    wr(`IDX_IRQ_ENABLE, 8'h02, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h1);
    wr(`IDX_IRQ_CLEAR, 8'h02, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h0);
    rdr(`IDX_IRQ_CLEAR, 8'h00, `RESP_OKAY);
  endtask
  task summarize;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reset for five edges, then the scenarios in order.
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_group0;
    t_group1;
    t_line0;
    t_irq;
    summarize;
  end
  // The whole run needs a few hundred cycles; this bound cuts a hang short.
  initial begin
    #200000;
    n_errors = n_errors + 1;
    summarize;
  end
endmodule
